// file: common/aux_io_pkg.sv
package aux_io_pkg;

    // APB register byte addresses
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] LUBE_INTERVAL_OFFSET = 8'h04;
    localparam logic [7:0] LUBE_ON_OFFSET = 8'h08;
    localparam logic [7:0] LUBE_HOLD_OFFSET = 8'h0C;
    localparam logic [7:0] CMD_OFFSET = 8'h10;
    localparam logic [7:0] STATUS_OFFSET = 8'h14;

    // Control register fields
    localparam int CTRL_CS_MASK_BIT = 0;
    localparam int CTRL_FH_MASK_BIT = 1;
    localparam int CTRL_KEEP_BIT = 2;
    localparam logic [2:0] CTRL_RESET_VALUE = 3'h0;

    // Command register fields (write one to execute)
    localparam int CMD_COOLANT_OUT_START_BIT = 0;
    localparam int CMD_COOLANT_OUT_STOP_BIT = 1;
    localparam int CMD_PROG_END_BIT = 2;
    localparam int CMD_LUBE_START_BIT = 3;
    localparam int CMD_LUBE_STOP_BIT = 4;
    localparam int CMD_RESET_BIT = 5;

    // Status register fields
    localparam int ST_COOLANT_OUT_BIT = 0;
    localparam int ST_LUBE_BIT = 1;
    localparam int ST_SKIP_BIT = 2;
    localparam int ST_LOCK_BIT = 3;
    localparam int ST_CS_BIT = 4;
    localparam int ST_FH_BIT = 5;

    // Timer parameter values count in milliseconds
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_TIME_PS = 1000000000;
    localparam int TICK_CYCLES = TICK_TIME_PS / CLK_PERIOD_PS;
    localparam logic [31:0] LUBE_INTERVAL_RESET = 32'h0000_0000;
    localparam logic [31:0] LUBE_ON_RESET = 32'h0000_0000;
    localparam logic [31:0] LUBE_HOLD_RESET = 32'h0000_0000;
    localparam logic [31:0] LUBE_HOLD_THRESHOLD = 32'h0000_0001;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_EDIT = 3'b000,
        MODE_AUTO = 3'b001,
        MODE_MDI = 3'b010,
        MODE_DNC = 3'b011,
        MODE_JOG = 3'b100,
        MODE_MPG = 3'b101,
        MODE_ZERO = 3'b110,
        MODE_STEP = 3'b111
    } op_mode_t;

    typedef enum logic [1:0] {
        LUBE_IDLE = 2'b00,
        LUBE_ON = 2'b01,
        LUBE_WAIT = 2'b10
    } lube_state_t;

endpackage

// file: hw/machine_aux_io_control.sv
// How it works
// [RQ1] Cycle-start mask set: external cycle-start input ignored; clear: honoured.
// [RQ2] Feed-hold mask set: external feed-hold input ignored; clear: honoured.
// [RQ3] Machine side must wire a stop switch when external feed hold enabled.
// [RQ4] Coolant output off from power-on until coolant-start executes.
// [RQ5] Coolant-start command sets coolant output and keeps it latched.
// [RQ6] Coolant-stop command clears latched coolant output.
// [RQ7] Coolant-stop drives no output of its own; only clears coolant.
// [RQ8] Program-end command also switches coolant off.
// [RQ9] Reset clears spindle, coolant, lube unless reset-keeps-outputs is set; the code leaves lube running in automatic mode.
// [RQ10] Zero lube on-time selects manual lube; nonzero selects automatic.
// [RQ11] Manual, hold time zero: each lube key press toggles lube output.
// [RQ12] Manual toggle mode: lube-start turns on, lube-stop turns off.
// [RQ13] Manual timed mode: key or start turns lube on, ends after hold time; the code keeps lube off for a hold time of 1.
// [RQ14] Timed mode: lube-stop cancels lube output at once.
// [RQ15] Automatic: lube for on-time, pause interval, repeat from power-on.
// [RQ16] Automatic mode: lube commands and lube key have no effect.
// [RQ17] Block skip active: slash-marked blocks skipped without execution.
// [RQ18] Block skip acts only in auto, MDI and DNC modes.
// [RQ19] Machine lock honoured in every operating mode.
// [RQ20] Machine lock state cannot change while a program runs.
// [RQ21] Panel indicators follow the active state of their functions.
`timescale 1ns/1ps

module machine_aux_io_control
    import aux_io_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_cycle_start_i,
    input wire logic ext_feed_hold_i,
    input wire logic cycle_start_key_i,
    input wire logic feed_hold_key_i,
    input wire logic lube_key_i,
    input wire logic block_skip_key_i,
    input wire logic machine_lock_key_i,
    input wire logic [2:0] op_mode_i,
    input wire logic prog_running_i,
    input wire logic spindle_run_i,
    output logic cycle_start_o,
    output logic feed_hold_o,
    output logic coolant_out_o,
    output logic lube_out_o,
    output logic spindle_enable_o,
    output logic skip_slash_blocks_o,
    output logic machine_lock_o,
    output logic cycle_start_led_o,
    output logic feed_hold_led_o,
    output logic coolant_led_o,
    output logic lube_led_o,
    output logic block_skip_led_o,
    output logic machine_lock_led_o
);

    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    // Two-stage synchronisers for all pin inputs
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [2:0] key_prev_q;
    assign pins_raw = {spindle_run_i, prog_running_i, op_mode_i, machine_lock_key_i,
                       block_skip_key_i, lube_key_i, feed_hold_key_i, cycle_start_key_i,
                       ext_feed_hold_i, ext_cycle_start_i};

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // Previous key levels; reset equals the idle level, so no false press after reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            key_prev_q <= 3'h0;
        end else begin
            key_prev_q <= sync2_q[6:4];
        end
    end

    wire ext_cs_s = sync2_q[0];
    wire ext_fh_s = sync2_q[1];
    wire cs_key_s = sync2_q[2];
    wire fh_key_s = sync2_q[3];
    // Presses act on the rising edge only, so a held key toggles once
    wire lube_key_rise = rise(sync2_q[4], key_prev_q[0]);
    wire skip_key_rise = rise(sync2_q[5], key_prev_q[1]);
    wire lock_key_rise = rise(sync2_q[6], key_prev_q[2]);
    wire [2:0] mode_s = sync2_q[9:7];
    wire running_s = sync2_q[10];
    wire spindle_s = sync2_q[11];

    // APB slave, zero wait states
    logic [2:0] ctrl_q;
    logic [31:0] lube_interval_time_q;
    logic [31:0] lube_on_time_q;
    logic [31:0] lube_manual_hold_time_q;
    wire apb_access = psel_i & penable_i;
    wire apb_wr = apb_access & pwrite_i;
    wire hit_ctrl = paddr_i == CTRL_OFFSET;
    wire hit_int = paddr_i == LUBE_INTERVAL_OFFSET;
    wire hit_on = paddr_i == LUBE_ON_OFFSET;
    wire hit_hold = paddr_i == LUBE_HOLD_OFFSET;
    wire hit_cmd = paddr_i == CMD_OFFSET;
    wire hit_stat = paddr_i == STATUS_OFFSET;
    wire hit_any = hit_ctrl | hit_int | hit_on | hit_hold | hit_cmd | hit_stat;
    wire [31:0] cmd_w = (apb_wr & hit_cmd) ? pwdata_i : 32'h0000_0000;
    wire coolant_start_cmd = cmd_w[CMD_COOLANT_OUT_START_BIT];
    wire coolant_stop_cmd = cmd_w[CMD_COOLANT_OUT_STOP_BIT];
    wire program_end_cmd = cmd_w[CMD_PROG_END_BIT];
    wire lube_start_cmd = cmd_w[CMD_LUBE_START_BIT];
    wire lube_stop_cmd = cmd_w[CMD_LUBE_STOP_BIT];
    wire reset_key_cmd = cmd_w[CMD_RESET_BIT];
    wire ext_cycle_start_mask = ctrl_q[CTRL_CS_MASK_BIT];
    wire ext_feed_hold_mask = ctrl_q[CTRL_FH_MASK_BIT];
    wire reset_keeps_outputs = ctrl_q[CTRL_KEEP_BIT];
    wire reset_clears = reset_key_cmd & ~reset_keeps_outputs; // RQ9

    logic [5:0] status_w;
    wire [31:0] rd_mux =
        hit_ctrl ? {29'h0, ctrl_q} :
        hit_int ? lube_interval_time_q :
        hit_on ? lube_on_time_q :
        hit_hold ? lube_manual_hold_time_q :
        hit_stat ? {26'h0, status_w} : 32'h0000_0000;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RESET_VALUE;
        end else if (apb_wr && hit_ctrl) begin
            ctrl_q <= pwdata_i[2:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lube_interval_time_q <= LUBE_INTERVAL_RESET;
        end else if (apb_wr && hit_int) begin
            lube_interval_time_q <= pwdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lube_on_time_q <= LUBE_ON_RESET;
        end else if (apb_wr && hit_on) begin
            lube_on_time_q <= pwdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lube_manual_hold_time_q <= LUBE_HOLD_RESET;
        end else if (apb_wr && hit_hold) begin
            lube_manual_hold_time_q <= pwdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~hit_any;
            prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end
    // Write/read completes when pready high; pready follows setup by one cycle
    // so apb_wr is qualified by the access phase, one edge per transfer.

    // Cycle start and feed hold gating
    wire cs_d = cs_key_s | (ext_cs_s & ~ext_cycle_start_mask); // RQ1
    wire fh_d = fh_key_s | (ext_fh_s & ~ext_feed_hold_mask); // RQ2 RQ3

    // Coolant
    logic coolant_q;
    logic spindle_q;
    wire coolant_d = coolant_start_cmd ? 1'b1 : // RQ5
                     (coolant_stop_cmd | program_end_cmd | reset_clears) ? 1'b0 : // RQ6 RQ7 RQ8
                     coolant_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            coolant_q <= 1'b0; // RQ4
        end else begin
            coolant_q <= coolant_d;
        end
    end

    // Reset command with reset-keeps-outputs clear blanks the spindle for one cycle; the request then takes over again
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            spindle_q <= 1'b0;
        end else begin
            spindle_q <= spindle_s & ~reset_clears; // RQ9
        end
    end

    // Lubrication, timers count millisecond ticks
    logic [$clog2(TICK_LEN+1)-1:0] tick_cnt_q;
    wire tick = tick_cnt_q == ($clog2(TICK_LEN+1))'(TICK_LEN - 1);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
        end
    end

    lube_state_t lube_state_q;
    lube_state_t lube_state_d;
    logic [31:0] lube_cnt_q;
    logic [31:0] lube_cnt_d;
    wire auto_mode = lube_on_time_q != 32'h0000_0000; // RQ10
    wire timed_mode = lube_manual_hold_time_q > LUBE_HOLD_THRESHOLD; // RQ13
    wire toggle_mode = lube_manual_hold_time_q == 32'h0000_0000; // RQ11
    wire cnt_done = lube_cnt_q == 32'h0000_0000;

    always_comb begin
        lube_state_d = lube_state_q;
        lube_cnt_d = (tick && !cnt_done) ? lube_cnt_q - 32'h1 : lube_cnt_q;
        if (auto_mode) begin
            // Keys and lube commands ignored here
            unique case (lube_state_q) // RQ16
                LUBE_IDLE: begin
                    lube_state_d = LUBE_ON; // RQ15
                    lube_cnt_d = lube_on_time_q;
                end
                LUBE_ON: if (cnt_done) begin
                    lube_state_d = LUBE_WAIT; // RQ15
                    lube_cnt_d = lube_interval_time_q;
                end
                LUBE_WAIT: if (cnt_done) begin
                    lube_state_d = LUBE_ON; // RQ15
                    lube_cnt_d = lube_on_time_q;
                end
                default: lube_state_d = LUBE_IDLE;
            endcase
        end else if (toggle_mode) begin
            lube_cnt_d = 32'h0000_0000;
            if (lube_stop_cmd) lube_state_d = LUBE_IDLE; // RQ12
            else if (lube_start_cmd) lube_state_d = LUBE_ON; // RQ12
            else if (lube_key_rise) begin
                lube_state_d = (lube_state_q == LUBE_ON) ? LUBE_IDLE : LUBE_ON; // RQ11
            end
        end else if (timed_mode) begin
            if (lube_stop_cmd) begin
                lube_state_d = LUBE_IDLE; // RQ14
                lube_cnt_d = 32'h0000_0000;
            end else if (lube_start_cmd | lube_key_rise) begin
                lube_state_d = LUBE_ON; // RQ13
                lube_cnt_d = lube_manual_hold_time_q;
            end else if (lube_state_q != LUBE_IDLE && cnt_done) begin
                lube_state_d = LUBE_IDLE; // RQ13
            end
        end else begin
            lube_state_d = LUBE_IDLE;
            lube_cnt_d = 32'h0000_0000;
        end
        if (reset_clears && !auto_mode) begin
            lube_state_d = LUBE_IDLE; // RQ9
            lube_cnt_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lube_state_q <= LUBE_IDLE;
            lube_cnt_q <= 32'h0000_0000;
        end else begin
            lube_state_q <= lube_state_d;
            lube_cnt_q <= lube_cnt_d;
        end
    end

    // Block skip and machine lock
    logic skip_q;
    logic lock_q;
    wire mode_prog = (mode_s == MODE_AUTO) | (mode_s == MODE_MDI) | (mode_s == MODE_DNC);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            skip_q <= 1'b0;
        end else if (skip_key_rise) begin
            skip_q <= ~skip_q;
        end
    end

    // Lock presses during a running program are dropped, not held for later
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lock_q <= 1'b0;
        end else if (lock_key_rise && !running_s) begin
            lock_q <= ~lock_q; // RQ20
        end
    end
    wire skip_active = skip_q & mode_prog; // RQ17 RQ18
    wire lube_on = lube_state_q == LUBE_ON;

    assign status_w = {fh_d, cs_d, lock_q, skip_active, lube_on, coolant_q};

    // Each function output and its indicator share one source, so they never differ
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cycle_start_o <= 1'b0;
            cycle_start_led_o <= 1'b0;
        end else begin
            cycle_start_o <= cs_d;
            cycle_start_led_o <= cs_d; // RQ21
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            feed_hold_o <= 1'b0;
            feed_hold_led_o <= 1'b0;
        end else begin
            feed_hold_o <= fh_d;
            feed_hold_led_o <= fh_d; // RQ21
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            coolant_out_o <= 1'b0;
            coolant_led_o <= 1'b0;
        end else begin
            coolant_out_o <= coolant_q;
            coolant_led_o <= coolant_q; // RQ21
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lube_out_o <= 1'b0;
            lube_led_o <= 1'b0;
        end else begin
            lube_out_o <= lube_on;
            lube_led_o <= lube_on; // RQ21
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            spindle_enable_o <= 1'b0;
        end else begin
            spindle_enable_o <= spindle_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            skip_slash_blocks_o <= 1'b0;
            block_skip_led_o <= 1'b0;
        end else begin
            skip_slash_blocks_o <= skip_active; // RQ17
            block_skip_led_o <= skip_active; // RQ21
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            machine_lock_o <= 1'b0;
            machine_lock_led_o <= 1'b0;
        end else begin
            machine_lock_o <= lock_q; // RQ19
            machine_lock_led_o <= lock_q; // RQ21
        end
    end

endmodule

// file: dv/panel_model.sv
`timescale 1ns/1ps

module panel_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] press_i,
    input wire logic start_sw_i,
    input wire logic stop_sw_i,
    output logic [2:0] key_o,
    output logic ext_cycle_start_o,
    output logic ext_feed_hold_o
);
    logic [3:0] hold_q [3];

    // A press keeps the key down long enough to pass the input synchronisers
    always_ff @(posedge clk_i or posedge rst_i) begin
        for (int k = 0; k < 3; k++) begin
            if (rst_i) begin
                hold_q[k] <= 4'h0;
            end else if (press_i[k]) begin
                hold_q[k] <= 4'h6;
            end else if (hold_q[k] != 4'h0) begin
                hold_q[k] <= hold_q[k] - 4'h1;
            end
        end
    end

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            key_o[k] = (hold_q[k] != 4'h0);
        end
    end

    // Stop switch is wired to the feed-hold input
    assign ext_feed_hold_o = stop_sw_i;
    assign ext_cycle_start_o = start_sw_i;
endmodule

// file: dv/aux_io_monitor.sv
`timescale 1ns/1ps

module aux_io_monitor
    import aux_io_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [2:0] op_mode_i,
    input wire logic prog_running_i,
    input wire logic coolant_out_o,
    input wire logic coolant_led_o,
    input wire logic lube_out_o,
    input wire logic lube_led_o,
    input wire logic skip_slash_blocks_o,
    input wire logic block_skip_led_o,
    input wire logic machine_lock_o,
    input wire logic machine_lock_led_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    wire cmd_wr = psel_i && penable_i && pready_o && pwrite_i && (paddr_i == CMD_OFFSET);
    wire coolant_out_on = cmd_wr && pwdata_i[CMD_COOLANT_OUT_START_BIT];
    wire coolant_out_off = cmd_wr && !pwdata_i[CMD_COOLANT_OUT_START_BIT]
        && (pwdata_i[CMD_COOLANT_OUT_STOP_BIT] || pwdata_i[CMD_PROG_END_BIT]);
    wire other_mode = !(op_mode_i inside {MODE_AUTO, MODE_MDI, MODE_DNC});

    a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready in access phase");
    a_unmapped_err: assert property (psel_i && !penable_i && paddr_i > STATUS_OFFSET |=> pslverr_o)
        else $error("unmapped access without error");
    a_coolant_out_start: assert property (coolant_out_on |-> ##2 coolant_out_o)
        else $error("coolant not set by start");
    a_coolant_out_stop: assert property (coolant_out_off |-> ##2 !coolant_out_o)
        else $error("coolant not cleared");
    a_coolant_out_cause: assert property ($rose(coolant_out_o) |-> $past(coolant_out_on, 2))
        else $error("coolant rose without start");
    a_led_follow: assert property (coolant_led_o == coolant_out_o && lube_led_o == lube_out_o
        && block_skip_led_o == skip_slash_blocks_o && machine_lock_led_o == machine_lock_o)
        else $error("indicator differs from function");
    a_skip_mode: assert property (other_mode [*5] |-> !skip_slash_blocks_o)
        else $error("block skip active in wrong mode");
    a_lock_frozen: assert property (prog_running_i [*6] |=> $stable(machine_lock_o))
        else $error("lock changed while running");

    cover property (coolant_out_on);
    cover property ($rose(skip_slash_blocks_o));
    cover property ($rose(machine_lock_o));
    cover property ($rose(lube_out_o));
endmodule

bind machine_aux_io_control aux_io_monitor aux_io_monitor_inst (.clk_sys_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .op_mode_i,
    .prog_running_i, .coolant_out_o, .coolant_led_o, .lube_out_o, .lube_led_o,
    .skip_slash_blocks_o, .block_skip_led_o, .machine_lock_o, .machine_lock_led_o);

// file: dv/machine_aux_io_control_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end

module machine_aux_io_control_tb;
    import aux_io_pkg::*;
    localparam int TL = 4;
    logic clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdata;
    logic [2:0] op_mode_i = 3'h0, press = 3'h0, keys;
    logic prog_running_i = 0, spindle_run_i = 0, start_sw = 0, stop_sw = 0, rerr;
    logic ext_cycle_start_i, ext_feed_hold_i, pready_o, pslverr_o, cycle_start_o, feed_hold_o;
    logic coolant_out_o, lube_out_o, spindle_enable_o, skip_slash_blocks_o, machine_lock_o;
    logic cycle_start_led_o, feed_hold_led_o, coolant_led_o, lube_led_o, block_skip_led_o;
    logic machine_lock_led_o;
    logic [31:0] cv [6] = '{32'h1, 32'h2, 32'h1, 32'h4, 32'h3, 32'h2};
    logic ce [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    int errors = 0, tests_run = 0, n;

    machine_aux_io_control #(.TICK_LEN(TL)) machine_aux_io_control_inst (.clk_sys_i, .rst_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .ext_cycle_start_i, .ext_feed_hold_i, .cycle_start_key_i(1'b0), .feed_hold_key_i(1'b0),
        .lube_key_i(keys[0]), .block_skip_key_i(keys[1]), .machine_lock_key_i(keys[2]),
        .op_mode_i, .prog_running_i, .spindle_run_i, .cycle_start_o, .feed_hold_o,
        .coolant_out_o, .lube_out_o, .spindle_enable_o, .skip_slash_blocks_o, .machine_lock_o,
        .cycle_start_led_o, .feed_hold_led_o, .coolant_led_o, .lube_led_o, .block_skip_led_o,
        .machine_lock_led_o);

    panel_model panel_model_inst (.clk_i(clk_sys_i), .rst_i, .press_i(press),
        .start_sw_i(start_sw), .stop_sw_i(stop_sw), .key_o(keys),
        .ext_cycle_start_o(ext_cycle_start_i), .ext_feed_hold_o(ext_feed_hold_i));

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys_i);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            errors++;
            complete_run();
        end
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask

    task automatic push(input int k);
        @(posedge clk_sys_i);
        press[k] <= 1;
        @(posedge clk_sys_i);
        press[k] <= 0;
        cyc(10);
    endtask

    task automatic wait_lube(input logic v, output int c);
        c = 0;
        while (lube_out_o !== v) begin
            @(posedge clk_sys_i);
            c++;
            if (c > 200) begin
                errors++;
                complete_run();
            end
        end
    endtask

    initial begin
        cyc(20);
        rst_i <= 0;
        for (int i = 0; i < 6; i++) begin
            apb(0, 8'(4 * i), 32'h0);
            `CHK(rdata, 32'h0)
        end
        apb(0, 8'h18, 32'h0);
        `CHK(rerr, 1'h1)
        for (int i = 0; i < 6; i++) begin
            apb(1, CMD_OFFSET, cv[i]);
            apb(0, STATUS_OFFSET, 32'h0);
            `CHK(rdata[ST_COOLANT_OUT_BIT], ce[i])
            `CHK(coolant_out_o, ce[i])
            `CHK(lube_out_o, 1'h0)
        end
        spindle_run_i <= 1;
        for (int k = 0; k < 2; k++) begin
            apb(1, CTRL_OFFSET, 32'(4 * k));
            apb(1, CMD_OFFSET, 32'h1);
            apb(1, CMD_OFFSET, 32'h20);
            cyc(2);
            `CHK(coolant_out_o, 1'(k))
            `CHK(spindle_enable_o, 1'(k))
        end
        for (int m = 0; m < 2; m++) begin
            apb(1, CTRL_OFFSET, 32'(3 * m));
            start_sw <= 1;
            cyc(6);
            `CHK(cycle_start_o, 1'(m == 0))
            `CHK(cycle_start_led_o, 1'(m == 0))
            start_sw <= 0;
            stop_sw <= 1;
            cyc(6);
            `CHK(feed_hold_o, 1'(m == 0))
            `CHK(feed_hold_led_o, 1'(m == 0))
            stop_sw <= 0;
            cyc(6);
        end
        push(0);
        `CHK(lube_out_o, 1'h1)
        push(0);
        `CHK(lube_out_o, 1'h0)
        apb(1, CMD_OFFSET, 32'h8);
        cyc(3);
        `CHK(lube_out_o, 1'h1)
        apb(1, CMD_OFFSET, 32'h10);
        cyc(3);
        `CHK(lube_out_o, 1'h0)
        apb(1, LUBE_HOLD_OFFSET, 32'h3);
        apb(1, CMD_OFFSET, 32'h8);
        cyc(3);
        `CHK(lube_out_o, 1'h1)
        wait_lube(0, n);
        `CHK(n >= TL && n <= 4 * TL + 2, 1'h1)
        apb(1, LUBE_HOLD_OFFSET, 32'h8);
        push(0);
        `CHK(lube_out_o, 1'h1)
        apb(1, CMD_OFFSET, 32'h10);
        cyc(3);
        `CHK(lube_out_o, 1'h0)
        apb(1, LUBE_HOLD_OFFSET, 32'h0);
        apb(1, LUBE_INTERVAL_OFFSET, 32'h3);
        apb(1, LUBE_ON_OFFSET, 32'h3);
        wait_lube(1, n);
        apb(1, CMD_OFFSET, 32'h10);
        cyc(2);
        `CHK(lube_out_o, 1'h1)
        wait_lube(0, n);
        wait_lube(1, n);
        `CHK(n >= 2 * TL && n <= 4 * TL + 2, 1'h1)
        apb(1, LUBE_ON_OFFSET, 32'h0);
        apb(1, CMD_OFFSET, 32'h10);
        cyc(3);
        `CHK(lube_out_o, 1'h0)
        op_mode_i <= MODE_AUTO;
        push(1);
        for (int md = 0; md < 8; md++) begin
            op_mode_i <= 3'(md);
            cyc(6);
            `CHK(skip_slash_blocks_o, 1'(md >= 1 && md <= 3))
            `CHK(block_skip_led_o, 1'(md >= 1 && md <= 3))
        end
        op_mode_i <= MODE_JOG;
        push(2);
        `CHK(machine_lock_o, 1'h1)
        prog_running_i <= 1;
        cyc(4);
        push(2);
        `CHK(machine_lock_o, 1'h1)
        prog_running_i <= 0;
        cyc(4);
        push(2);
        `CHK(machine_lock_o, 1'h0)
        complete_run();
    end
endmodule
